// ===== src/adc_seq_pkg.sv
// Constants, field layouts and types for the converter sequencer
package adc_seq_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CLKSEL_OFS  = 8'h04;
  localparam logic [7:0] TIMING_OFS  = 8'h08;
  localparam logic [7:0] MUX_OFS     = 8'h0C;
  localparam logic [7:0] CMD_OFS     = 8'h10;
  localparam logic [7:0] INTEN_OFS   = 8'h14;
  localparam logic [7:0] FLAGS_OFS   = 8'h18;
  localparam logic [7:0] RESULT_OFS  = 8'h1C;
  localparam logic [7:0] WINLO_OFS   = 8'h20;
  localparam logic [7:0] WINHI_OFS   = 8'h24;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] winMode;     // Window compare mode
    logic       delayVary;   // Randomise sample delay
    logic [2:0] accCountSel; // 2**n samples per trigger, n <= 6
    logic       evtStartEn;  // Event start enable
    logic       bitDepthSel; // 1 = 8-bit result
    logic       autoRepeat;  // Free-running mode
    logic       enable;      // Converter enable
  } ctrl_t;

  typedef struct packed {
    logic [1:0] reference_select;      // Reference select
    logic [2:0] divSel;      // Prescale factor 2**(n+1)
  } clksel_t;

  typedef struct packed {
    logic [3:0] lenCycles;   // Extra sample length
    logic [3:0] dlyCycles;   // Extra sample delay
  } timing_t;

  typedef struct packed {
    logic win;               // Window compare hit
    logic done;              // Sample done
  } flags_t;

  localparam ctrl_t   CTRL_RST   = '0;
  localparam clksel_t CLKSEL_RST = '0;
  localparam timing_t TIMING_RST = '0;
  localparam flags_t  FLAGS_RST  = '0;

  localparam int MUX_W  = 5;
  localparam int DATA_W = 10;
  localparam int ACC_W  = 16;
  localparam int PRE_W  = 8;

  // ----------------------------------------------------------------
  // Timing and modes
  // ----------------------------------------------------------------
  localparam logic [4:0] CONV_CYCLES  = 5'h0D;  // Converter clocks per conversion
  localparam logic [4:0] SH_CYCLES    = 5'h02;  // Start to sample-and-hold
  localparam logic [7:0] START_EXTRA  = 8'h02;  // Fixed part of start latency
  localparam logic [2:0] ACC_SEL_MAX  = 3'h6;   // 64 samples
  localparam logic [1:0] DEPTH_SHIFT  = 2'h2;   // 10-bit to 8-bit

  localparam logic [2:0] WIN_OFF     = 3'h0;
  localparam logic [2:0] WIN_BELOW   = 3'h1;
  localparam logic [2:0] WIN_ABOVE   = 3'h2;
  localparam logic [2:0] WIN_INSIDE  = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_CONV = 3'b100
  } seq_state_t;

endpackage : adc_seq_pkg

// ===== src/adc_conversion_sequencer.sv
// Conversion sequencer: APB registers, prescaler, timing, accumulation
// Notes on behaviour
// - Writing start bit begins conversion; bit reads one while busy; single mode clears it
// - Channel change during conversion applies only from that conversion's last converter clock cycle
// - Done flag sets when single conversion or whole accumulated burst finishes
// - Interrupt only when done or window flag, that flag's enable and global enable are all one
// - Done flag sets even with interrupt disabled, for polling
// - With event start enabled, a routed event arriving while idle triggers a conversion
// - Event input is edge sensitive; edge sets start bit, cleared at completion
// - Free-running: software starts first, next starts right after completion, each sets done
// - Converter clock prescaled from peripheral clock; counter held zero while disabled
// - Prescaler held in reset while no conversion is in progress
// - Conversion starts half prescale factor plus two peripheral clocks after trigger
// - A normal conversion lasts thirteen converter clock cycles
// - Sample-and-hold capture two converter clocks after start with no extra timing
// - Result placed in output word; done clears on result read or write one
// - Sampling lasts two plus sample delay plus sample length converter clocks
// - Result presented right-adjusted in output word
// - Reference and channel selections take effect only while enabled
// - Accumulation sums a programmable number of conversions into one result
// - Optional variation randomises the sample delay within a burst
// - Window compare limits interrupts to under, over, inside or outside thresholds
// - Selections locked at start; updating resumes in last converter clock cycle
// - Accumulator sums up to sixty-four samples per result
`timescale 1ns/1ns
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input  wire logic              mclk,       // Peripheral clock, 100 MHz
  input  wire logic              rst,        // Asynchronous reset, active high
  input  wire logic              ce,         // Clock enable, freezes all state when low
  input  wire logic              psel,       // APB select
  input  wire logic              penable,    // APB enable
  input  wire logic              pwrite,     // APB direction
  input  wire logic [7:0]        paddr,      // APB byte address
  input  wire logic [31:0]       pwdata,     // APB write data
  output logic      [31:0]       prdata,     // APB read data
  output logic                   pready,     // APB ready
  output logic                   pslverr,    // APB error on unmapped address
  input  wire logic              globalIe,   // Processor global interrupt enable
  input  wire logic              eventIn,    // Start event from event routing
  input  wire logic [DATA_W-1:0] anaData,    // Raw value from analog core
  output logic                   irq,        // Interrupt request
  output logic                   sampleHold, // Sample-and-hold capture pulse
  output logic      [MUX_W-1:0]  activeMux,  // Applied positive input select
  output logic      [1:0]        activeRef   // Applied reference select
);

  // ----------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------
  ctrl_t              ctrl_ff;
  clksel_t            clk_ff;
  timing_t            tim_ff;
  flags_t             flags_ff;
  seq_state_t         state_ff;
  logic [MUX_W-1:0]   muxBuf_ff;
  logic [1:0]         ieBits_ff;
  logic [DATA_W-1:0]  winLo_ff, winHi_ff;
  logic [ACC_W-1:0]   result_ff, acc_ff;
  logic               startBit_ff;
  logic [PRE_W-1:0]   clock_divider_select_ff, wait_ff;
  logic [5:0]         adcCyc_ff;
  logic [4:0]         dlyEff_ff;
  logic [5:0]         accN_ff;
  logic [7:0]         lfsr_ff;
  logic               evS1_ff, evS2_ff, evS3_ff;
  logic [DATA_W-1:0]  anaS1_ff, anaS2_ff;
  logic [31:0]        prdata_ff;
  logic               pready_ff, pslverr_ff, irq_ff, sh_ff;
  logic [MUX_W-1:0]   actMux_ff;
  logic [1:0]         actRef_ff;

  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign irq        = irq_ff;
  assign sampleHold = sh_ff;
  assign activeMux  = actMux_ff;
  assign activeRef  = actRef_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [7:0] a);
    mapped = a inside {CTRL_OFS, CLKSEL_OFS, TIMING_OFS, MUX_OFS, CMD_OFS,
                       INTEN_OFS, FLAGS_OFS, RESULT_OFS, WINLO_OFS, WINHI_OFS};
  endfunction : mapped

  function automatic logic winHit(input logic [2:0] m, input logic [ACC_W-1:0] v,
                                  input logic [DATA_W-1:0] lo,
                                  input logic [DATA_W-1:0] hi);
    unique case (m)
      WIN_BELOW:   winHit = v < ACC_W'(lo);
      WIN_ABOVE:   winHit = v > ACC_W'(hi);
      WIN_INSIDE:  winHit = (v > ACC_W'(lo)) && (v < ACC_W'(hi));
      WIN_OUTSIDE: winHit = (v < ACC_W'(lo)) || (v > ACC_W'(hi));
      default:     winHit = 1'b0;
    endcase
  endfunction : winHit

  logic              wrEn, rdEn, busy, trigger, evtRise, tick, lastCyc, convEnd;
  logic              accLast, startCmd;
  logic [PRE_W-1:0]  factor, half;
  // Six bits: thirteen plus the widest delay and length overflows five
  logic [5:0]        total, shAt;
  logic [4:0]        nxt_dlyEff;
  logic [2:0]        accSel;
  logic [DATA_W-1:0] sample;
  logic [ACC_W-1:0]  sum;

  assign wrEn     = ce && psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign rdEn     = ce && psel && penable && pready_ff && !pwrite && !pslverr_ff;
  assign busy     = state_ff != S_IDLE;
  assign evtRise  = evS2_ff && !evS3_ff;
  assign startCmd = wrEn && paddr == CMD_OFS && pwdata[0];
  // Triggers during a conversion are dropped so the running one is untouched
  assign trigger  = ctrl_ff.enable && !busy &&
                    (startCmd || (ctrl_ff.evtStartEn && evtRise));
  assign factor   = PRE_W'(2) << clk_ff.divSel;
  // Taken from the select itself: the largest factor wraps to zero in PRE_W bits
  assign half     = PRE_W'(1) << clk_ff.divSel;
  assign tick     = state_ff == S_CONV && clock_divider_select_ff == factor - PRE_W'(1);
  assign total    = 6'(CONV_CYCLES) + 6'(dlyEff_ff) + 6'(tim_ff.lenCycles);
  assign shAt     = 6'(SH_CYCLES) + 6'(dlyEff_ff) + 6'(tim_ff.lenCycles);
  assign lastCyc  = state_ff == S_CONV && adcCyc_ff == total - 6'(1);
  assign convEnd  = tick && lastCyc;
  assign accSel   = (ctrl_ff.accCountSel > ACC_SEL_MAX) ? ACC_SEL_MAX : ctrl_ff.accCountSel;
  assign accLast  = accN_ff == 6'((7'(1) << accSel) - 7'(1));
  assign sample   = ctrl_ff.bitDepthSel ? (anaS2_ff >> DEPTH_SHIFT) : anaS2_ff;
  assign sum      = acc_ff + ACC_W'(sample);
  assign nxt_dlyEff = 5'(tim_ff.dlyCycles) +
                      (ctrl_ff.delayVary ? 5'(lfsr_ff[1:0]) : 5'(0));

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      evS1_ff  <= 1'b0;
      evS2_ff  <= 1'b0;
      evS3_ff  <= 1'b0;
      anaS1_ff <= '0;
      anaS2_ff <= '0;
    end else if (ce) begin
      evS1_ff  <= eventIn;
      evS2_ff  <= evS1_ff;
      evS3_ff  <= evS2_ff;
      anaS1_ff <= anaData;
      anaS2_ff <= anaS1_ff;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, no wait state; read data registered during the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (ce) begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          CTRL_OFS:   prdata_ff <= 32'(ctrl_ff);
          CLKSEL_OFS: prdata_ff <= 32'(clk_ff);
          TIMING_OFS: prdata_ff <= 32'(tim_ff);
          MUX_OFS:    prdata_ff <= 32'(muxBuf_ff);
          CMD_OFS:    prdata_ff <= 32'(startBit_ff);
          INTEN_OFS:  prdata_ff <= 32'(ieBits_ff);
          FLAGS_OFS:  prdata_ff <= 32'(flags_ff);
          RESULT_OFS: prdata_ff <= 32'(result_ff);
          WINLO_OFS:  prdata_ff <= 32'(winLo_ff);
          WINHI_OFS:  prdata_ff <= 32'(winHi_ff);
          default:    prdata_ff <= '0;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff   <= CTRL_RST;
      clk_ff    <= CLKSEL_RST;
      tim_ff    <= TIMING_RST;
      muxBuf_ff <= '0;
      ieBits_ff <= '0;
      winLo_ff  <= '0;
      winHi_ff  <= '0;
    end else if (wrEn) begin
      unique case (paddr)
        CTRL_OFS:   ctrl_ff   <= ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
        CLKSEL_OFS: clk_ff    <= clksel_t'(pwdata[$bits(clksel_t)-1:0]);
        TIMING_OFS: tim_ff    <= timing_t'(pwdata[$bits(timing_t)-1:0]);
        MUX_OFS:    muxBuf_ff <= pwdata[MUX_W-1:0];
        INTEN_OFS:  ieBits_ff <= pwdata[1:0];
        WINLO_OFS:  winLo_ff  <= pwdata[DATA_W-1:0];
        WINHI_OFS:  winHi_ff  <= pwdata[DATA_W-1:0];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff    <= S_IDLE;
      startBit_ff <= 1'b0;
      wait_ff     <= '0;
      dlyEff_ff   <= '0;
    end else if (ce) begin
      if (!ctrl_ff.enable) begin
        state_ff    <= S_IDLE;
        startBit_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          S_IDLE: if (trigger) begin
            startBit_ff <= 1'b1;
            state_ff    <= S_WAIT;
            wait_ff     <= half + START_EXTRA - PRE_W'(1);
          end
          S_WAIT: begin
            if (wait_ff == '0) begin
              state_ff  <= S_CONV;
              dlyEff_ff <= nxt_dlyEff;
            end else begin
              wait_ff <= wait_ff - PRE_W'(1);
            end
          end
          S_CONV: if (convEnd) begin
            dlyEff_ff <= nxt_dlyEff;
            if (accLast && !ctrl_ff.autoRepeat) begin
              startBit_ff <= 1'b0;
              state_ff    <= S_IDLE;
            end
            // Burst members and free-running repeats restart at once
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // Prescaler and converter-cycle count, both idle at zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clock_divider_select_ff  <= '0;
      adcCyc_ff <= '0;
      sh_ff     <= 1'b0;
    end else if (ce) begin
      sh_ff <= tick && adcCyc_ff + 6'(1) == shAt;
      if (!ctrl_ff.enable || state_ff != S_CONV) begin
        clock_divider_select_ff  <= '0;
        adcCyc_ff <= '0;
      end else if (tick) begin
        clock_divider_select_ff  <= '0;
        adcCyc_ff <= convEnd ? 6'(0) : adcCyc_ff + 6'(1);
      end else begin
        clock_divider_select_ff <= clock_divider_select_ff + PRE_W'(1);
      end
    end
  end

  // Accumulation and result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_ff    <= '0;
      accN_ff   <= '0;
      result_ff <= '0;
    end else if (ce) begin
      if (!ctrl_ff.enable || state_ff == S_IDLE) begin
        acc_ff  <= '0;
        accN_ff <= '0;
      end else if (convEnd) begin
        if (accLast) begin
          result_ff <= sum;
          acc_ff    <= '0;
          accN_ff   <= '0;
        end else begin
          acc_ff  <= sum;
          accN_ff <= accN_ff + 6'(1);
        end
      end
    end
  end

  // Flags: a set in the same cycle as a clear wins
  logic doneSet, winSet, doneClr, winClr;
  assign doneSet = convEnd && accLast;
  assign winSet  = doneSet && winHit(ctrl_ff.winMode, sum, winLo_ff, winHi_ff);
  assign doneClr = (wrEn && paddr == FLAGS_OFS && pwdata[0]) ||
                   (rdEn && paddr == RESULT_OFS);
  assign winClr  = wrEn && paddr == FLAGS_OFS && pwdata[1];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_ff <= FLAGS_RST;
      irq_ff   <= 1'b0;
    end else if (ce) begin
      flags_ff.done <= doneSet || (flags_ff.done && !doneClr);
      flags_ff.win  <= winSet || (flags_ff.win && !winClr);
      irq_ff <= globalIe && ((flags_ff.done && ieBits_ff[0]) ||
                             (flags_ff.win && ieBits_ff[1]));
    end
  end

  // Applied selections: follow buffer only when safe and enabled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      actMux_ff <= '0;
      actRef_ff <= '0;
      lfsr_ff   <= LFSR_SEED;
    end else if (ce) begin
      lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & LFSR_TAPS)};
      if (ctrl_ff.enable && (state_ff != S_CONV || lastCyc)) begin
        actMux_ff <= muxBuf_ff;
        actRef_ff <= clk_ff.reference_select;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] waitCnt_ff, convCnt_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitCnt_ff <= '0;
      convCnt_ff <= '0;
    end else if (ce) begin
      waitCnt_ff <= (state_ff == S_WAIT) ? waitCnt_ff + 16'(1) : 16'(0);
      convCnt_ff <= (state_ff == S_CONV && !convEnd) ? convCnt_ff + 16'(1) : 16'(0);
    end
  end

  sequence s_evtTrig;
    ce && ctrl_ff.enable && ctrl_ff.evtStartEn && evtRise && state_ff == S_IDLE;
  endsequence
  sequence s_startWaits;
    ce && state_ff == S_WAIT ##1 state_ff == S_WAIT;
  endsequence

  property p_busyBit;
    @(posedge mclk) disable iff (rst) state_ff == S_CONV |-> startBit_ff;
  endproperty
  a_busyBit: assert property (p_busyBit) else $error("start bit low in conversion");

  property p_muxLock;
    @(posedge mclk) disable iff (rst)
      ce && state_ff == S_CONV && !lastCyc |=> $stable(actMux_ff) && $stable(actRef_ff);
  endproperty
  a_muxLock: assert property (p_muxLock) else $error("selection changed mid conversion");

  property p_doneSet;
    @(posedge mclk) disable iff (rst) ce && doneSet |=> flags_ff.done && result_ff == $past(sum);
  endproperty
  a_doneSet: assert property (p_doneSet) else $error("done flag or result missing");

  property p_irq;
    @(posedge mclk) disable iff (rst)
      $rose(irq_ff) |-> $past(globalIe) && ($past(flags_ff.done) || $past(flags_ff.win));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");

  property p_prescOff;
    @(posedge mclk) disable iff (rst) ce && !ctrl_ff.enable |=> clock_divider_select_ff == '0;
  endproperty
  a_prescOff: assert property (p_prescOff) else $error("prescaler runs while disabled");

  property p_startLat;
    @(posedge mclk) disable iff (rst)
      s_startWaits ##0 (ce && wait_ff == '0) |=>
        state_ff == S_CONV && waitCnt_ff == 16'(half + START_EXTRA);
  endproperty
  a_startLat: assert property (p_startLat) else $error("start latency wrong");

  property p_convLen;
    @(posedge mclk) disable iff (rst)
      ce && convEnd |-> convCnt_ff == 16'(total) * 16'({half, 1'b0}) - 16'(1);
  endproperty
  a_convLen: assert property (p_convLen) else $error("conversion length wrong");

  property p_shTime;
    @(posedge mclk) disable iff (rst)
      ce && $rose(sh_ff) |-> convCnt_ff == 16'(shAt) * 16'({half, 1'b0});
  endproperty
  a_shTime: assert property (p_shTime) else $error("sample capture misplaced");

  property p_evtStart;
    @(posedge mclk) disable iff (rst) s_evtTrig |=> startBit_ff && state_ff == S_WAIT;
  endproperty
  a_evtStart: assert property (p_evtStart) else $error("event did not start");

  property p_noRestart;
    @(posedge mclk) disable iff (rst)
      ce && ctrl_ff.enable && state_ff == S_CONV && !convEnd |=> state_ff == S_CONV;
  endproperty
  a_noRestart: assert property (p_noRestart) else $error("conversion disturbed");

endmodule : adc_conversion_sequencer

// ===== verif/adc_far_side.sv
// Far-side model: event source and analog core value
`timescale 1ns/1ns
module adc_far_side
  import adc_seq_pkg::*;
(
  input  wire logic              mclk,    // Peripheral clock
  input  wire logic              fire,    // Bench asks for one event
  input  wire logic [DATA_W-1:0] value,   // Level the analog core settles to
  output logic                   eventIn, // Event line to the sequencer
  output logic      [DATA_W-1:0] anaData  // Analog core output
);
  logic [2:0] pulseLen_ff = 3'h0;

  // Pulse held several cycles so the two-flop synchroniser cannot miss it
  always_ff @(posedge mclk) begin
    if (fire) begin
      pulseLen_ff <= 3'h4;
    end else if (pulseLen_ff != 3'h0) begin
      pulseLen_ff <= pulseLen_ff - 3'h1;
    end
  end

  assign eventIn = (pulseLen_ff != 3'h0);
  assign anaData = value;
endmodule : adc_far_side

// ===== verif/test_adc_conversion_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module test_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  logic              mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic              pwrite = 1'b0, globalIe = 1'b0, fire = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata, rd, m, ex;
  logic              pready, pslverr, irq, sampleHold, eventIn;
  logic [DATA_W-1:0] anaData;
  logic [DATA_W-1:0] anaVal = '0;
  logic [MUX_W-1:0]  activeMux;
  logic [1:0]        activeRef;
  logic [32:0]       e;
  logic [32:0]       expQ[$];
  logic [31:0]       mskQ[$];
  logic [15:0]       lfsr = 16'hC8BC;
  int                miscompares = 0, comparisons = 0, holds = 0, f;
  time               tTrig, tStart, tHold, tGap;
  ctrl_t             cfg;
  timing_t           tm;
  clksel_t           cs;

  always #5 mclk = ~mclk;

  adc_conversion_sequencer u_adc_conversion_sequencer (
    .mclk(mclk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .globalIe(globalIe), .eventIn(eventIn),
    .anaData(anaData), .irq(irq), .sampleHold(sampleHold),
    .activeMux(activeMux), .activeRef(activeRef));

  adc_far_side u_adc_far_side (.mclk(mclk), .fire(fire), .value(anaVal),
    .eventIn(eventIn), .anaData(anaData));

  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nextRand

  task miss(input string s);
    miscompares++;
    $display("unexpected at %0t: %s", $time, s);
  endtask : miss

  task check(input bit c, input string s);
    comparisons++;
    if (!c) miss(s);
  endtask : check

  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // Request held until pready is sampled high; one idle edge after release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miss("no ready");
      wrap_up();
    end
    rd = prdata;
    tTrig = $time;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task rdChk(input logic [7:0] a, input logic [32:0] x, input logic [31:0] k);
    expQ.push_back(x);
    mskQ.push_back(k);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rdChk

  task waitDone;
    for (int i = 0; i < 1000; i++) begin
      apb(1'b0, FLAGS_OFS, 32'h0000_0000);
      if (rd[0] === 1'b1) break;
    end
    if (rd[0] !== 1'b1) begin
      miss("done never set");
      wrap_up();
    end
  endtask : waitDone

  task waitHolds(input int nh);
    for (int i = 0; i < 3000 && holds < nh; i++) @(posedge mclk);
    if (holds < nh) begin
      miss("no capture pulse");
      wrap_up();
    end
  endtask : waitHolds

  // Oldest note is compared at each completed read
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      comparisons++;
      if ({pslverr, prdata & m} !== e) miss("read value");
    end
  end

  always @(posedge sampleHold) begin
    if (holds == 0) tHold = $time;
    if (holds == 1) tGap = $time - tHold;
    holds++;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    miss("timeout");
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdChk(CTRL_OFS, 33'h0, 32'hFFFF_FFFF);
    rdChk(CMD_OFS, 33'h0, 32'hFFFF_FFFF);
    rdChk(FLAGS_OFS, 33'h0, 32'hFFFF_FFFF);
    rdChk(8'h40, 33'h1_0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, MUX_OFS, 32'h0000_0005);
    check(activeMux === 5'h00, "selection applied while disabled");
    for (int k = 0; k < 3; k++) begin
      lfsr = nextRand(lfsr);
      anaVal <= lfsr[15:6];
      cs = {2'h1, 1'b0, lfsr[1:0]};
      tm = {lfsr[9:8], 2'b00, lfsr[5:4]} >> 0;
      tm.lenCycles = {2'b00, lfsr[9:8]};
      tm.dlyCycles = {2'b00, lfsr[5:4]};
      f = 2 << lfsr[1:0];
      cfg = '0;
      cfg.enable = 1'b1;
      cfg.accCountSel = (k == 1) ? 3'h2 : 3'h0;
      cfg.bitDepthSel = (k == 2);
      globalIe <= (k != 0);
      apb(1'b1, CLKSEL_OFS, {27'h0, cs});
      apb(1'b1, TIMING_OFS, {24'h0, tm});
      apb(1'b1, CTRL_OFS, {21'h0, cfg});
      apb(1'b1, INTEN_OFS, 32'h0000_0001);
      check(activeMux === 5'h05, "selection not applied on enable");
      holds = 0;
      apb(1'b1, CMD_OFS, 32'h0000_0001);
      tStart = tTrig;
      waitHolds(1);
      apb(1'b1, MUX_OFS, 32'h0000_0009);
      check(activeMux === 5'h05, "selection changed mid-conversion");
      rdChk(CMD_OFS, 33'h1, 32'h0000_0001);
      apb(1'b1, CMD_OFS, 32'h0000_0001);
      waitDone();
      check(tHold - tStart == ((f / 2 + 2) + (2 + tm.dlyCycles + tm.lenCycles) * f) * 10,
            "capture time");
      check(holds == ((k == 1) ? 4 : 1), "capture count");
      if (k == 1) check(tGap == (13 + tm.dlyCycles + tm.lenCycles) * f * 10, "gap");
      check(irq === (k != 0), "interrupt level");
      check(activeMux === 5'h09, "selection not applied after end");
      ex = (k == 1) ? {20'h0, anaVal, 2'b00} : {22'h0, anaVal};
      if (k == 2) ex = ex >> DEPTH_SHIFT;
      rdChk(RESULT_OFS, {1'b0, ex}, 32'h0000_FFFF);
      rdChk(FLAGS_OFS, 33'h0, 32'h0000_0001);
      rdChk(CMD_OFS, 33'h0, 32'h0000_0001);
      apb(1'b1, CTRL_OFS, 32'h0000_0000);
      apb(1'b1, MUX_OFS, 32'h0000_0005);
      check(activeMux === 5'h09, "selection applied while disabled");
    end
    apb(1'b1, CTRL_OFS, 32'h0000_0009);
    holds = 0;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    waitHolds(1);
    rdChk(CMD_OFS, 33'h1, 32'h0000_0001);
    waitDone();
    check(holds == 1, "event conversions");
    rdChk(RESULT_OFS, {23'h0, anaVal}, 32'h0000_FFFF);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    holds = 0;
    apb(1'b1, CMD_OFS, 32'h0000_0001);
    waitHolds(3);
    rdChk(FLAGS_OFS, 33'h1, 32'h0000_0001);
    rdChk(CMD_OFS, 33'h1, 32'h0000_0001);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b1, FLAGS_OFS, 32'h0000_0001);
    rdChk(FLAGS_OFS, 33'h0, 32'h0000_0001);
    rdChk(CMD_OFS, 33'h0, 32'h0000_0001);
    wrap_up();
  end
endmodule : test_adc_conversion_sequencer
